// >>> hw/mbrs_slave.sv
// RTU slave of a motor drive: receiver, request check, register map,
// reply builder, reply FIFO and transmitter.
// Assumes one 10 MHz clock; cfg and status come from logic on that clock.
//
// Functional notes
// - Characters: start, eight data, stop, no parity.
// - Rate 9600 to 115200, default 115200.
// - Only function 03 and function 06.
// - Read: count, then two bytes per register.
// - Write reply echoes address and value.
// - Control bit0 run, bit1 second ramp.
// - Control bit2 fault reset, bit3 coast stop.
// - Register 2 speed setpoint, hertz times ten.
// - Register 4 ramp time, hundredths of second.
// - Register 6: error low, state high.
// - Register 7 output frequency times ten.
// - Register 8 output current times ten.
// - Register 11 four digital input levels.
// - Registers 20, 21 analog inputs percent.
// - Register 22 active speed reference.
// - Register 23 bus volts, 24 heatsink.
// - Settings reachable as holding registers too.
// - Settings writes ignored while run enabled.
// - All values are sixteen-bit integers.
// - Answer only own address 0 to 63.
// - Watchdog off, 300 ms or 3000 ms.
`timescale 1ns/1ps
`default_nettype none
`include "mbrs_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Reply byte FIFO: drained by the transmitter, stalls the reply builder.
module mbrs_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk_sys,   // System clock.
	input  wire logic         rst_n,     // Synchronous reset, active low.
	input  wire logic         in_valid,  // Byte offered.
	output logic              in_ready,  // Room for a byte.
	input  wire logic [W-1:0] in_data,   // Byte written.
	output logic              out_valid, // Byte available.
	input  wire logic         out_ready, // Byte taken.
	output logic [W-1:0]      out_data   // Oldest byte.
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [0:D-1];
	logic [AW:0]  wp_reg;
	logic [AW:0]  rp_reg;

	// Full when pointers differ only in the wrap bit.
	assign in_ready  = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
	assign out_valid = (wp_reg != rp_reg);
	assign out_data  = mem[rp_reg[AW-1:0]];

	// Storage write.
	always_ff @(posedge clk_sys) begin
		if (in_valid && in_ready) begin
			mem[wp_reg[AW-1:0]] <= in_data;
		end
	end

	// Pointer update.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (out_valid && out_ready) begin
				rp_reg <= rp_reg + 1'b1;
			end
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Slave top.
module mbrs_slave
	import mbrs_pkg::*;
#(
	parameter logic [24:0] WDOG_SHORT_CYC = 25'(`MBRS_WDOG_SHORT_CYC), // 300 ms in cycles.
	parameter logic [24:0] WDOG_LONG_CYC  = 25'(`MBRS_WDOG_LONG_CYC)   // 3000 ms in cycles.
) (
	input  wire logic         clk_sys,     // System clock, 10 MHz.
	input  wire logic         rst_n,       // Synchronous reset, active low.
	input  wire logic         rx_pin,      // Line receiver output.
	output logic              tx_pin,      // Line driver data.
	output logic              tx_oe,       // Line driver enable, high while driving.
	input  wire mbrs_cfg_t    cfg,         // Address, rate and watchdog selection.
	input  wire mbrs_status_t status,      // Live drive values.
	output var mbrs_ctrl_t    ctrl,        // Control bits and setpoints.
	output logic              wdog_expired // No valid traffic within the timeout.
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Reflected CRC-16 over one byte.
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `MBRS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// Clocks per bit for a rate selection; unknown codes use the default rate.
	function automatic logic [15:0] baud_div(input logic [2:0] s);
		int unsigned r;
		case (s)
			3'h0:    r = `MBRS_BAUD_0;
			3'h1:    r = `MBRS_BAUD_1;
			3'h2:    r = `MBRS_BAUD_2;
			3'h3:    r = `MBRS_BAUD_3;
			default: r = `MBRS_BAUD_4;
		endcase
		return 16'((`MBRS_CLK_HZ + r / 2) / r);
	endfunction

	logic [15:0] div;
	logic [15:0] gap_cyc;
	assign div     = baud_div(cfg.baud_sel);
	assign gap_cyc = div * `MBRS_GAP_BITS;

	////////////////////////////////////////////////////////////////////////////
	// Receiver.
	logic        rx_s1;
	logic        rx_s2;
	mbrs_rx_t    rx_state;
	logic [15:0] rx_cnt;
	logic [2:0]  rx_bit;
	logic [7:0]  rx_sh;
	logic        byte_ok;
	logic        frame_err;
	logic        rx_tick;
	assign rx_tick = (rx_cnt == 16'h0000);

	// Two-stage synchroniser on the line.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
		end else begin
			rx_s1 <= rx_pin;
			rx_s2 <= rx_s1;
		end
	end

	// Start found, bits sampled mid-cell, stop checked; no parity cell.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rx_state  <= RX_IDLE;
			rx_cnt    <= 16'h0000;
			rx_bit    <= 3'h0;
			rx_sh     <= 8'h00;
			byte_ok   <= 1'b0;
			frame_err <= 1'b0;
		end else begin
			byte_ok   <= 1'b0;
			frame_err <= 1'b0;
			rx_cnt    <= rx_tick ? div - 16'h0001 : rx_cnt - 16'h0001;
			unique case (rx_state)
				RX_IDLE: begin
					rx_cnt <= div >> 1;
					if (!rx_s2) begin
						rx_state <= RX_START;
					end
				end
				RX_START: begin
					if (rx_tick) begin
						rx_bit   <= 3'h0;
						rx_state <= rx_s2 ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_sh  <= {rx_s2, rx_sh[7:1]};
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == 3'h7) begin
							rx_state <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_tick) begin
						byte_ok   <= rx_s2;
						frame_err <= !rx_s2;
						rx_state  <= RX_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Telegram capture and check.
	logic [7:0]  req_mem [0:7];
	logic [3:0]  rx_len;
	logic [15:0] crc_reg;
	logic        bad_reg;
	logic [15:0] gap_cnt;
	logic        busy;
	logic        eof;
	logic        accept;
	logic        is_rd;
	logic        is_wr;
	logic [15:0] req_a;
	logic [15:0] req_v;
	logic        addr_ok;
	logic        cnt_ok;

	assign req_a   = {req_mem[2], req_mem[3]};
	assign req_v   = {req_mem[4], req_mem[5]};
	assign is_rd   = (req_mem[1] == `MBRS_FN_READ);
	assign is_wr   = (req_mem[1] == `MBRS_FN_WRITE);
	assign cnt_ok  = (req_v != 16'h0000) && (req_v <= `MBRS_MAX_READ);
	assign addr_ok = (req_mem[0] == {2'h0, cfg.addr});
	assign eof     = (rx_len != 4'h0) && (gap_cnt == gap_cyc);
	// Silent drop unless length, CRC, address, function and read count all hold, with no framing error and no reply pending.
	assign accept  = eof && !busy && !bad_reg && (rx_len == `MBRS_REQ_LEN)
		&& (crc_reg == 16'h0000) && addr_ok && ((is_rd && cnt_ok) || is_wr);

	// Line-idle time, counted while the receiver rests on a high line.
	always_ff @(posedge clk_sys) begin
		if (!rst_n || rx_state != RX_IDLE || !rx_s2) begin
			gap_cnt <= 16'h0000;
		end else if (gap_cnt != gap_cyc) begin
			gap_cnt <= gap_cnt + 16'h0001;
		end
	end

	// Request bytes; bytes heard while a reply is pending are ignored.
	always_ff @(posedge clk_sys) begin
		if (byte_ok && !busy && rx_len < `MBRS_REQ_LEN) begin
			req_mem[rx_len[2:0]] <= rx_sh;
		end
	end

	// Length, running CRC and error flag of the telegram in progress.
	always_ff @(posedge clk_sys) begin
		if (!rst_n || eof) begin
			rx_len  <= 4'h0;
			crc_reg <= `MBRS_CRC_INIT;
			bad_reg <= 1'b0;
		end else if (!busy && (byte_ok || frame_err)) begin
			rx_len  <= (rx_len == 4'h9) ? rx_len : rx_len + 4'h1;
			crc_reg <= crc_step(crc_reg, rx_sh);
			bad_reg <= bad_reg || frame_err || (rx_len == `MBRS_REQ_LEN);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register map. Register number is the address field plus one.
	logic [15:0] ctrl_reg;
	logic [15:0] spd_reg;
	logic [15:0] ramp_reg;
	logic [15:0] par_mem [0:`MBRS_PAR_NUM-1];
	logic [15:0] wr_num;
	logic        wr_go;
	logic        wr_par;
	logic [5:0]  wr_pidx;
	logic [15:0] par_sel_val;

	assign wr_num      = req_a + 16'h0001;
	assign wr_go       = accept && is_wr;
	assign wr_par      = (wr_num >= `MBRS_PAR_FIRST) && (wr_num <= `MBRS_PAR_LAST);
	assign wr_pidx     = 6'(wr_num - `MBRS_PAR_FIRST);
	assign par_sel_val = par_mem[wr_pidx];

	// Read value of one register number; unmapped numbers read zero.
	function automatic logic [15:0] rd_word(input logic [15:0] n);
		logic [15:0] r;
		r = 16'h0000;
		case (n)
			`MBRS_REG_CTRL:  r = ctrl_reg;
			`MBRS_REG_SPEED: r = spd_reg;
			`MBRS_REG_RAMP:  r = ramp_reg;
			`MBRS_REG_STATE: r = {status.state, status.fault_code};
			`MBRS_REG_FREQ:  r = status.out_freq;
			`MBRS_REG_CURR:  r = status.out_curr;
			`MBRS_REG_DIN:   r = {12'h000, status.din};
			`MBRS_REG_AIN1:  r = status.ain1;
			`MBRS_REG_AIN2:  r = status.ain2;
			`MBRS_REG_SREF:  r = status.spd_ref;
			`MBRS_REG_DCBUS: r = status.dc_bus;
			`MBRS_REG_TEMP:  r = status.temp;
			default: begin
				if (n >= `MBRS_PAR_FIRST && n <= `MBRS_PAR_LAST) begin
					r = par_mem[6'(n - `MBRS_PAR_FIRST)];
				end
			end
		endcase
		return r;
	endfunction

	// Writable control registers; other numbers accept the write silently.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctrl_reg <= `MBRS_CTRL_RST;
			spd_reg  <= `MBRS_SPEED_RST;
			ramp_reg <= `MBRS_RAMP_RST;
		end else if (wr_go) begin
			if (wr_num == `MBRS_REG_CTRL) ctrl_reg <= req_v;
			if (wr_num == `MBRS_REG_SPEED) spd_reg <= req_v;
			if (wr_num == `MBRS_REG_RAMP) ramp_reg <= req_v;
		end
	end

	// Drive settings; locked while the run enable is set.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `MBRS_PAR_NUM; i++) begin
				par_mem[i] <= `MBRS_PAR_RST;
			end
		end else if (wr_go && wr_par && !ctrl_reg[`MBRS_CTRL_RUN]) begin
			par_mem[wr_pidx] <= req_v;
		end
	end

	// Control outputs straight from the control word and setpoints.
	assign ctrl.run       = ctrl_reg[`MBRS_CTRL_RUN];
	assign ctrl.ramp2     = ctrl_reg[`MBRS_CTRL_RAMP2];
	assign ctrl.fault_rst = ctrl_reg[`MBRS_CTRL_FRST];
	assign ctrl.coast     = ctrl_reg[`MBRS_CTRL_COAST];
	assign ctrl.setpoint  = spd_reg;
	assign ctrl.ramp_time = ramp_reg;

	////////////////////////////////////////////////////////////////////////////
	// Reply builder feeding the FIFO one byte per accepted slot.
	mbrs_bld_t   bld_state;
	logic [6:0]  widx;
	logic [6:0]  words;
	logic [15:0] tx_crc;
	logic [15:0] tx_word;
	logic [7:0]  in_data;
	logic        in_valid;
	logic        in_ready;
	logic        in_fire;

	assign words    = is_wr ? 7'h02 : req_v[6:0];
	assign tx_word  = is_wr ? ((widx == 7'h00) ? req_a : req_v)
		: rd_word(req_a + {9'h000, widx} + 16'h0001);
	assign in_valid = (bld_state != TB_IDLE);
	assign in_fire  = in_valid && in_ready;
	assign in_data  = (bld_state == TB_ADDR) ? {2'h0, cfg.addr}
		: (bld_state == TB_FUNC) ? req_mem[1]
		: (bld_state == TB_BCNT) ? {req_v[6:0], 1'b0}
		: (bld_state == TB_DHI)  ? tx_word[15:8]
		: (bld_state == TB_DLO)  ? tx_word[7:0]
		: (bld_state == TB_CRCL) ? tx_crc[7:0] : tx_crc[15:8];

	// Sequence: address, function, [count], words high first, CRC low first.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bld_state <= TB_IDLE;
			widx      <= 7'h00;
			tx_crc    <= `MBRS_CRC_INIT;
		end else if (accept) begin
			bld_state <= TB_ADDR;
			widx      <= 7'h00;
			tx_crc    <= `MBRS_CRC_INIT;
		end else if (in_fire) begin
			if (bld_state != TB_CRCL && bld_state != TB_CRCH) begin
				tx_crc <= crc_step(tx_crc, in_data);
			end
			unique case (bld_state)
				TB_ADDR: bld_state <= TB_FUNC;
				TB_FUNC: bld_state <= is_rd ? TB_BCNT : TB_DHI;
				TB_BCNT: bld_state <= TB_DHI;
				TB_DHI:  bld_state <= TB_DLO;
				TB_DLO: begin
					widx      <= widx + 7'h01;
					bld_state <= (widx + 7'h01 == words) ? TB_CRCL : TB_DHI;
				end
				TB_CRCL: bld_state <= TB_CRCH;
				TB_CRCH: bld_state <= TB_IDLE;
				TB_IDLE: bld_state <= TB_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// FIFO and transmitter.
	logic       f_valid;
	logic       f_ready;
	logic [7:0] f_data;
	mbrs_tx_t   tx_state;
	logic [9:0] tx_sh;
	logic [3:0] tx_bits;
	logic [15:0] tx_cnt;
	logic       tx_oe_reg;
	logic       tx_take;

	mbrs_fifo #(.W(8), .D(`MBRS_FIFO_DEPTH)) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_data   (in_data),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	assign f_ready = (tx_state == TX_IDLE);
	assign tx_take = f_valid && f_ready;
	assign tx_pin  = tx_sh[0];
	assign tx_oe   = tx_oe_reg;
	assign busy    = in_valid || tx_oe_reg;

	// Shifts start, eight data bits LSB first, stop; holds the driver on
	// until the FIFO and builder are both empty.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tx_state  <= TX_IDLE;
			tx_sh     <= 10'h3FF;
			tx_bits   <= 4'h0;
			tx_cnt    <= 16'h0000;
			tx_oe_reg <= 1'b0;
		end else begin
			unique case (tx_state)
				TX_IDLE: begin
					if (f_valid) begin
						tx_sh     <= {1'b1, f_data, 1'b0};
						tx_bits   <= 4'hA;
						tx_cnt    <= div - 16'h0001;
						tx_oe_reg <= 1'b1;
						tx_state  <= TX_SHIFT;
					end else if (!in_valid) begin
						tx_oe_reg <= 1'b0;
					end
				end
				TX_SHIFT: begin
					tx_cnt <= tx_cnt - 16'h0001;
					if (tx_cnt == 16'h0000) begin
						tx_sh   <= {1'b1, tx_sh[9:1]};
						tx_bits <= tx_bits - 4'h1;
						tx_cnt  <= div - 16'h0001;
						if (tx_bits == 4'h1) begin
							tx_state <= TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Communication watchdog, restarted by each accepted telegram.
	logic [24:0] wd_cnt;
	logic [24:0] wd_lim;
	logic        wd_on;
	assign wd_on  = (cfg.wdog_sel == 2'h1) || (cfg.wdog_sel == 2'h2);
	assign wd_lim = (cfg.wdog_sel == 2'h1) ? WDOG_SHORT_CYC : WDOG_LONG_CYC;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wd_cnt       <= 25'h0000000;
			wdog_expired <= 1'b0;
		end else if (accept || !wd_on) begin
			wd_cnt       <= 25'h0000000;
			wdog_expired <= 1'b0;
		end else if (wd_cnt == wd_lim) begin
			wdog_expired <= 1'b1;
		end else begin
			wd_cnt <= wd_cnt + 25'h0000001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	sequence s_reply_open;
		bld_state == TB_ADDR ##[1:16] bld_state == TB_FUNC;
	endsequence

	a_start_bit_low: assert property (tx_take |=> !tx_pin)
		else $error("start bit not low");
	a_stop_bit_high: assert property (tx_state == TX_SHIFT && tx_bits == 4'h1 |-> tx_pin)
		else $error("stop bit not high");
	a_default_rate: assert property (cfg.baud_sel == `MBRS_BAUD_DEF |-> div == 16'h0057)
		else $error("default rate divisor wrong");
	a_func_filter: assert property (accept |-> is_rd || is_wr)
		else $error("unsupported function accepted");
	a_byte_count: assert property (in_fire && bld_state == TB_BCNT
		|-> in_data == {req_v[6:0], 1'b0})
		else $error("byte count wrong");
	a_reply_order: assert property (accept |=> s_reply_open)
		else $error("reply does not open with address and function");
	a_ctrl_write: assert property (wr_go && wr_num == `MBRS_REG_CTRL
		|=> ctrl_reg == $past(req_v) && ctrl.run == $past(req_v[0]))
		else $error("control word not written");
	a_param_lock: assert property (wr_go && wr_par && ctrl_reg[`MBRS_CTRL_RUN]
		|=> par_sel_val == $past(par_sel_val))
		else $error("setting changed while running");
	a_crc_discard: assert property (eof && crc_reg != 16'h0000 |-> !accept ##1 !in_valid)
		else $error("bad CRC answered");
	a_addr_match: assert property (accept |-> req_mem[0][7:6] == 2'h0
		&& req_mem[0][5:0] == cfg.addr)
		else $error("foreign address answered");
	a_gap_end: assert property (eof |-> $past(rx_state, 2) == RX_IDLE && gap_cnt == gap_cyc)
		else $error("telegram ended without idle gap");
	a_wdog_expire: assert property ($rose(wdog_expired) |-> $past(wd_cnt) == $past(wd_lim)
		&& $past(wd_on))
		else $error("watchdog expired at wrong count");
endmodule
`default_nettype wire

// >>> hw/mbrs_map.svh
// Constants of the RTU drive slave: register numbers, control bits,
// telegram codes, reset values and timing.
// Assumes a 10 MHz system clock; included by the package and the slave.
`ifndef MBRS_MAP_SVH
`define MBRS_MAP_SVH
`define MBRS_CLK_HZ         10000000
`define MBRS_BAUD_0         9600
`define MBRS_BAUD_1         19200
`define MBRS_BAUD_2         38400
`define MBRS_BAUD_3         57600
`define MBRS_BAUD_4         115200
`define MBRS_BAUD_DEF       3'h4
`define MBRS_GAP_BITS       16'h0023
`define MBRS_WDOG_SHORT_MS  300
`define MBRS_WDOG_LONG_MS   3000
`define MBRS_WDOG_SHORT_CYC (`MBRS_WDOG_SHORT_MS * (`MBRS_CLK_HZ / 1000))
`define MBRS_WDOG_LONG_CYC  (`MBRS_WDOG_LONG_MS * (`MBRS_CLK_HZ / 1000))
`define MBRS_FN_READ        8'h03
`define MBRS_FN_WRITE       8'h06
`define MBRS_REQ_LEN        4'h8
`define MBRS_MAX_READ       16'h007D
`define MBRS_REG_CTRL       16'h0001
`define MBRS_REG_SPEED      16'h0002
`define MBRS_REG_RAMP       16'h0004
`define MBRS_REG_STATE      16'h0006
`define MBRS_REG_FREQ       16'h0007
`define MBRS_REG_CURR       16'h0008
`define MBRS_REG_DIN        16'h000B
`define MBRS_REG_AIN1       16'h0014
`define MBRS_REG_AIN2       16'h0015
`define MBRS_REG_SREF       16'h0016
`define MBRS_REG_DCBUS      16'h0017
`define MBRS_REG_TEMP       16'h0018
`define MBRS_PAR_FIRST      16'h0081
`define MBRS_PAR_LAST       16'h00AF
`define MBRS_PAR_NUM        47
`define MBRS_CTRL_RUN       0
`define MBRS_CTRL_RAMP2     1
`define MBRS_CTRL_FRST      2
`define MBRS_CTRL_COAST     3
`define MBRS_CTRL_RST       16'h0000
`define MBRS_SPEED_RST      16'h0000
`define MBRS_RAMP_RST       16'h0000
`define MBRS_PAR_RST        16'h0000
`define MBRS_FIFO_DEPTH     16
`define MBRS_CRC_INIT       16'hFFFF
`define MBRS_CRC_POLY       16'hA001
`endif

// >>> hw/mbrs_pkg.sv
// Types of the RTU drive slave: grouped ports and state encodings.
// Assumes the constants header is on the include path.
`include "mbrs_map.svh"
package mbrs_pkg;

	// Live drive values shown in the read-only registers.
	typedef struct packed {
		logic [7:0]  fault_code;
		logic [7:0]  state;
		logic [15:0] out_freq;
		logic [15:0] out_curr;
		logic [3:0]  din;
		logic [15:0] ain1;
		logic [15:0] ain2;
		logic [15:0] spd_ref;
		logic [15:0] dc_bus;
		logic [15:0] temp;
	} mbrs_status_t;

	// Control word fields and setpoints handed to the motor control.
	typedef struct packed {
		logic        run;
		logic        ramp2;
		logic        fault_rst;
		logic        coast;
		logic [15:0] setpoint;
		logic [15:0] ramp_time;
	} mbrs_ctrl_t;

	// Link settings from the drive configuration.
	typedef struct packed {
		logic [5:0] addr;
		logic [2:0] baud_sel;
		logic [1:0] wdog_sel;
	} mbrs_cfg_t;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mbrs_rx_t;
	typedef enum logic [3:0] {TB_IDLE, TB_ADDR, TB_FUNC, TB_BCNT, TB_DHI, TB_DLO,
		TB_CRCL, TB_CRCH} mbrs_bld_t;
	typedef enum logic {TX_IDLE, TX_SHIFT} mbrs_tx_t;

endpackage

// >>> tb/mbrs_master_model.sv
// Bus master model for the drive slave: sends 8N1 requests, takes replies.
// Assumes 115200 bit/s at a 10 MHz clock and a pair biased idle high.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module mbrs_master_model #(
	parameter int DIV = 87 // Clocks per bit at 115200.
) (
	input  wire logic clk_sys,  // System clock.
	input  wire logic tx_pin,   // Slave driver data.
	input  wire logic tx_oe,    // Slave driver enable.
	output logic      line_out  // Master drive onto the pair.
);
	logic [7:0] tx_buf [0:31]; // Request bytes.
	logic [7:0] rx_buf [0:31]; // Reply bytes, room for the longest reply used.

	initial line_out = 1'b1;

	// Computes the frame check; a whole good frame leaves zero.
	function automatic logic [15:0] crc16(input logic [7:0] f [0:31], input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < n; i++) begin
			c = c ^ {8'h00, f[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	// Sends a silent gap, then one 8-byte request, CRC low byte first.
	task automatic send_req(input logic [7:0] a, input logic [7:0] fn,
		input logic [15:0] ra, input logic [15:0] v, input logic bad);
		logic [15:0] c;
		logic [9:0]  sh;
		repeat (40 * DIV) @(posedge clk_sys);
		tx_buf[0] = a;
		tx_buf[1] = fn;
		{tx_buf[2], tx_buf[3], tx_buf[4], tx_buf[5]} = {ra, v};
		c = crc16(tx_buf, 6) ^ {15'h0000, bad};
		{tx_buf[7], tx_buf[6]} = c;
		for (int j = 0; j < 8; j++) begin
			sh = {1'b1, tx_buf[j], 1'b0};
			for (int i = 0; i < 10; i++) begin
				line_out <= sh[i];
				repeat (DIV) @(posedge clk_sys);
			end
		end
	endtask

	// Takes n reply characters at bit centres; ok drops on any framing fault.
	task automatic recv(input int n, output logic ok);
		int w;
		ok = 1'b1;
		for (int j = 0; j < n; j++) begin
			w = 0;
			while (!(tx_oe === 1'b1 && tx_pin === 1'b0) && w < 50 * DIV) begin
				@(posedge clk_sys);
				w++;
			end
			repeat (DIV / 2) @(posedge clk_sys);
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge clk_sys);
				rx_buf[j][i] = tx_pin;
			end
			repeat (DIV) @(posedge clk_sys);
			if (tx_pin !== 1'b1 || tx_oe !== 1'b1 || w >= 50 * DIV) ok = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench of the drive slave: writes, a block read, silent cases.
// Assumes the master model and a 10 MHz clock; slave address 17, 115200.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module testbench;
	import mbrs_pkg::*;
	typedef struct {logic [15:0] rn; logic [15:0] val; logic [35:0] ctl;} mbrs_row_t;
	logic         clk_sys = 1'b0;
	logic         rst_n;
	logic         line_m, tx_pin, tx_oe, wdog_expired, rx_pin, ok;
	mbrs_cfg_t    cfg;
	mbrs_status_t status;
	mbrs_ctrl_t   ctrl;
	int           mismatches = 0;
	int           cmp_count = 0;
	int           busy;
	logic [15:0]  exp_reg [0:7];
	mbrs_row_t    rows [0:2] = '{'{16'h0001, 16'h000F, {4'b1111, 32'h0}},
		'{16'h0002, 16'h0064, {4'b1111, 16'h0064, 16'h0000}},
		'{16'h0004, 16'h00FA, {4'b1111, 16'h0064, 16'h00FA}}};

	// Clock and the receiver view of the half-duplex pair.
	always #50 clk_sys = ~clk_sys;
	assign rx_pin = (tx_oe === 1'b1) ? tx_pin : line_m;

	mbrs_slave #(.WDOG_SHORT_CYC(25'd2000), .WDOG_LONG_CYC(25'd5000)) dut_u (
		.clk_sys(clk_sys), .rst_n(rst_n), .rx_pin(rx_pin), .tx_pin(tx_pin), .tx_oe(tx_oe),
		.cfg(cfg), .status(status), .ctrl(ctrl), .wdog_expired(wdog_expired));
	mbrs_master_model master_u (.clk_sys(clk_sys), .tx_pin(tx_pin), .tx_oe(tx_oe),
		.line_out(line_m));

	// Compares one value and counts it.
	task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Sends a request that must stay unanswered and leave the control word.
	task automatic silent(input logic [7:0] a, input logic bad);
		master_u.send_req(a, 8'h03 + 8'h03, 16'h0000, 16'h0001, bad);
		busy = 0;
		repeat (40 * 87) begin
			@(posedge clk_sys);
			busy += (tx_oe === 1'b1);
		end
		check(36'(busy), 36'h0, "silent driver");
		check(36'(ctrl), {4'b1111, 16'h0064, 16'h00FA}, "control kept");
	endtask

	// Cuts a hang short.
	initial begin
		repeat (150000) @(posedge clk_sys);
		mismatches++;
		$display("Error at %0t: watchdog ran out", $time);
		final_report();
	end

	initial begin
		rst_n <= 1'b0;
		cfg <= '{addr: 6'h11, baud_sel: 3'h4, wdog_sel: 2'h1};
		status <= '{8'h2C, 8'h01, 16'h0064, 16'h000A, 4'hA, 16'h03E8, 16'h01F4,
			16'h0064, 16'h0145, 16'h0028};
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		check(36'(ctrl), 36'h0, "reset control");
		check(36'({tx_oe, wdog_expired}), 36'h0, "reset outputs");
		$display("Test reset done");
		// Write rows: echo, CRC and control outputs.
		for (int r = 0; r < 3; r++) begin
			master_u.send_req(8'h11, 8'h06, rows[r].rn - 16'h0001, rows[r].val, 1'b0);
			master_u.recv(8, ok);
			check(36'(ok), 36'h1, "write framing");
			for (int j = 0; j < 6; j++) check(36'(master_u.rx_buf[j]),
				36'(master_u.tx_buf[j]), "echo");
			check(36'(master_u.crc16(master_u.rx_buf, 8)), 36'h0, "write crc");
			check(36'(ctrl), rows[r].ctl, "control");
		end
		$display("Test writes done");
		// Block read of registers 1 to 8, unmapped ones read zero.
		exp_reg = '{16'h000F, 16'h0064, 16'h0000, 16'h00FA, 16'h0000, 16'h012C,
			16'h0064, 16'h000A};
		master_u.send_req(8'h11, 8'h03, 16'h0000, 16'h0008, 1'b0);
		master_u.recv(21, ok);
		check(36'(ok), 36'h1, "read framing");
		check(36'({master_u.rx_buf[0], master_u.rx_buf[1], master_u.rx_buf[2]}),
			36'h110310, "read head");
		for (int j = 0; j < 8; j++) check(
			36'({master_u.rx_buf[3 + 2 * j], master_u.rx_buf[4 + 2 * j]}),
			36'(exp_reg[j]), "read word");
		check(36'(master_u.crc16(master_u.rx_buf, 21)), 36'h0, "read crc");
		$display("Test read done");
		silent(8'h11, 1'b1);
		silent(8'h12, 1'b0);
		check(36'(wdog_expired), 36'h1, "watchdog expiry");
		$display("Test silent done");
		final_report();
	end
endmodule
`default_nettype wire
